// >>> src/dhi_device.sv
// Purpose: Display end of the host port: decodes the pins, hands bytes on.
// Assumes: Link clock much faster than the host strobes; all pins synced.
// Notes: Pin logic runs on the link clock; the user side runs on ref_clk.
//
// Contract
// [RQ1] Two straps select one of four modes.
// [RQ2] Parallel modes use the 8-bit bidirectional bus.
// [RQ3] Serial: data on bit one, clock bit zero.
// [RQ4] Host grounds unused bits; bit two floats serially.
// [RQ5] Strobe mode: transfer starts enable high, select low.
// [RQ6] Strobe mode: direction high reads, low writes.
// [RQ7] Split mode: read starts read strobe low.
// [RQ8] Split mode: write starts write strobe low.
// [RQ9] Serial modes: host grounds both strobe pins.
// [RQ10] Data/command high means display memory data.
// [RQ11] Data/command low means command register byte.
// [RQ12] Chip select high ignores all strobes, clocks.
// [RQ13] Reset pin low reinitialises the device.
// [RQ14] Strobe mode: write captured at enable fall.
// [RQ15] Split mode: write latched at strobe rise.
// [RQ16] Split mode: read strobe rise ends read.
// [RQ17] Serial bytes: eight bits, MSB first, rising.
// [RQ18] Serial modes are write only.
`timescale 1ns/10ps
module dhi_device
  import dhi_pkg::*;
(
  // User-side clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Pin side, on the link clock.
  dhi_link_if.device link,
  // Received bytes.
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_dc,
  output logic overrun,
  input wire logic overrun_clr,
  // Read-back sources and read notice.
  input wire logic [7:0] rd_status,
  input wire logic [7:0] rd_mem,
  output logic rd_taken,
  output logic rd_taken_dc,
  // Initialisation state.
  output logic panel_init
);

  // ----------------------------------------------------------------------
  // Link domain: pin synchronisers
  // ----------------------------------------------------------------------
  logic [16:0] lsync1_q, lsync2_q;
  logic l_rst_s, l_ack_s, l_hi_s, l_lo_s, l_prst_n_s, l_cs_n_s, l_dc_s, l_a_s, l_b_s;
  logic [7:0] l_bus_s;
  logic ack_tgl_q, ack_tgl_d;

  // Every pin, and the two levels from ref_clk, pass two flops first.
  always_ff @(posedge link.link_clk) begin
    lsync1_q <= {rst, ack_tgl_q, link.iface_sel_hi, link.iface_sel_lo,
                 link.panel_reset_n, link.cs_n, link.dc_sel, link.rw_strobe,
                 link.dir_wr, link.host_bus};
    lsync2_q <= lsync1_q;
  end
  assign {l_rst_s, l_ack_s, l_hi_s, l_lo_s, l_prst_n_s, l_cs_n_s, l_dc_s, l_a_s, l_b_s,
          l_bus_s} = lsync2_q;

  // ----------------------------------------------------------------------
  // Link domain: transfer decode
  // ----------------------------------------------------------------------
  dhi_mode_t mode;
  logic lrst, cs_act, a_rise, a_fall, b_rise, sclk_rise, serial_in;
  logic a_p_q, a_p_d, b_p_q, b_p_d, sclk_p_q, sclk_p_d, ack_p_q, ack_p_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d, drv_q, drv_d;
  logic [8:0] wr_word_q, wr_word_d;
  logic wr_tgl_q, wr_tgl_d, rdq_tgl_q, rdq_tgl_d, rd_dc_q, rd_dc_d;
  logic rd_ok_q, rd_ok_d, oe_q, oe_d;
  logic wr_ev, wr_dc, rd_start, rd_win;
  logic [7:0] wr_byte;
  logic [7:0] rd_word_q, rd_word_d;

  assign mode = dhi_decode_mode(l_hi_s, l_lo_s); // [RQ1]
  assign lrst = l_rst_s | ~l_prst_n_s; // [RQ13]
  assign cs_act = ~l_cs_n_s; // [RQ12]
  assign a_rise = l_a_s & ~a_p_q;
  assign a_fall = ~l_a_s & a_p_q;
  assign b_rise = l_b_s & ~b_p_q;
  assign sclk_rise = l_bus_s[0] & ~sclk_p_q; // [RQ3]
  assign serial_in = l_bus_s[1]; // [RQ3]

  // Edges are judged on synced copies; data sampled in the same cycle as
  // the edge is aligned with it, since both went through equal stages.
  always_comb begin
    a_p_d = l_a_s;
    b_p_d = l_b_s;
    sclk_p_d = l_bus_s[0];
    ack_p_d = l_ack_s;
    bit_d = bit_q;
    shift_d = shift_q;
    drv_d = drv_q;
    wr_word_d = wr_word_q;
    wr_tgl_d = wr_tgl_q;
    rdq_tgl_d = rdq_tgl_q;
    rd_dc_d = rd_dc_q;
    rd_ok_d = rd_ok_q;
    wr_ev = 1'b0;
    wr_dc = l_dc_s; // [RQ10] [RQ11]
    wr_byte = l_bus_s; // [RQ2]
    rd_start = 1'b0;
    rd_win = 1'b0;
    case (mode)
      DHI_PAR_SD: begin
        wr_ev = cs_act & a_fall & ~l_b_s; // [RQ5] [RQ6] [RQ14]
        rd_start = cs_act & a_rise & l_b_s; // [RQ5] [RQ6]
        rd_win = cs_act & l_a_s & l_b_s;
      end
      DHI_PAR_SPLIT: begin
        wr_ev = cs_act & b_rise; // [RQ8] [RQ15]
        rd_start = cs_act & a_fall; // [RQ7]
        rd_win = cs_act & ~l_a_s; // [RQ16]
      end
      default: begin
        // Serial modes carry no reads at all.
        if (cs_act && sclk_rise) begin // [RQ18]
          shift_d = {shift_q[6:0], serial_in}; // [RQ17]
          bit_d = 3'(bit_q + 3'h1);
          wr_ev = (bit_q == BIT_LAST); // [RQ17]
        end
        wr_byte = {shift_q[6:0], serial_in};
        wr_dc = (mode == DHI_SER4) ? l_dc_s : 1'b0;
      end
    endcase
    // A deselect abandons any partial serial byte.
    if (!cs_act) begin
      bit_d = '0; // [RQ12]
    end
    if (wr_ev) begin
      wr_word_d = {wr_dc, wr_byte};
      wr_tgl_d = ~wr_tgl_q;
    end
    if (rd_start) begin
      rdq_tgl_d = ~rdq_tgl_q;
      rd_dc_d = l_dc_s; // [RQ10] [RQ11]
      rd_ok_d = 1'b0;
    end else if ((l_ack_s != ack_p_q) && rd_win) begin
      drv_d = rd_word_q;
      rd_ok_d = 1'b1;
    end
    if (!rd_win) begin
      rd_ok_d = 1'b0; // [RQ16]
    end
    oe_d = rd_win & rd_ok_d; // [RQ2] [RQ12]
  end

  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      a_p_q <= 1'b0;
      b_p_q <= 1'b0;
      sclk_p_q <= 1'b0;
      ack_p_q <= 1'b0;
      bit_q <= '0;
      shift_q <= BUS_RESET;
      drv_q <= BUS_RESET;
      wr_word_q <= '0;
      wr_tgl_q <= 1'b0;
      rdq_tgl_q <= 1'b0;
      rd_dc_q <= 1'b0;
      rd_ok_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      a_p_q <= a_p_d;
      b_p_q <= b_p_d;
      sclk_p_q <= sclk_p_d;
      ack_p_q <= ack_p_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      drv_q <= drv_d;
      wr_word_q <= wr_word_d;
      wr_tgl_q <= wr_tgl_d;
      rdq_tgl_q <= rdq_tgl_d;
      rd_dc_q <= rd_dc_d;
      rd_ok_q <= rd_ok_d;
      oe_q <= oe_d;
    end
  end

  assign link.dev_drv = drv_q;
  assign link.dev_oe = oe_q;

  // ----------------------------------------------------------------------
  // Reference domain: toggle crossings and user side
  // ----------------------------------------------------------------------
  logic [2:0] rsync1_q, rsync2_q;
  logic r_wr_s, r_rd_s, r_prst_n_s, rrst, wr_new, rd_new;
  logic wr_p_q, wr_p_d, rd_p_q, rd_p_d, ovr_q, ovr_d, tk_q, tk_d, tk_dc_q, tk_dc_d;
  logic buf_ready;
  logic [8:0] buf_out;

  always_ff @(posedge ref_clk) begin
    rsync1_q <= {wr_tgl_q, rdq_tgl_q, link.panel_reset_n};
    rsync2_q <= rsync1_q;
  end
  assign {r_wr_s, r_rd_s, r_prst_n_s} = rsync2_q;
  assign rrst = rst | ~r_prst_n_s; // [RQ13]
  assign wr_new = r_wr_s ^ wr_p_q;
  assign rd_new = r_rd_s ^ rd_p_q;

  // The word and flag behind a toggle were set a full sync time earlier,
  // so they are stable when read here. An arrival on a full buffer is
  // dropped and flagged; a new loss beats a clear in the same cycle.
  always_comb begin
    wr_p_d = r_wr_s;
    rd_p_d = r_rd_s;
    ovr_d = (ovr_q & ~overrun_clr) | (wr_new & ~buf_ready);
    rd_word_d = rd_word_q;
    ack_tgl_d = ack_tgl_q;
    tk_d = rd_new;
    tk_dc_d = tk_dc_q;
    if (rd_new) begin
      rd_word_d = rd_dc_q ? rd_mem : rd_status; // [RQ10] [RQ11]
      ack_tgl_d = ~ack_tgl_q;
      tk_dc_d = rd_dc_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rrst) begin
      wr_p_q <= 1'b0;
      rd_p_q <= 1'b0;
      ovr_q <= 1'b0;
      rd_word_q <= BUS_RESET;
      ack_tgl_q <= 1'b0;
      tk_q <= 1'b0;
      tk_dc_q <= 1'b0;
    end else begin
      wr_p_q <= wr_p_d;
      rd_p_q <= rd_p_d;
      ovr_q <= ovr_d;
      rd_word_q <= rd_word_d;
      ack_tgl_q <= ack_tgl_d;
      tk_q <= tk_d;
      tk_dc_q <= tk_dc_d;
    end
  end

  // Two entries absorb a short stall by the consumer.
  dhi_buf2 #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_buf (
    .clk(ref_clk),
    .rst(rrst),
    .in_valid(wr_new),
    .in_ready(buf_ready),
    .in_data(wr_word_q),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_out)
  );

  assign {out_dc, out_data} = buf_out;
  assign overrun = ovr_q;
  assign rd_taken = tk_q;
  assign rd_taken_dc = tk_dc_q;
  assign panel_init = ~r_prst_n_s;
endmodule : dhi_device

// >>> shared/dhi_pkg.sv
// Purpose: Shared types, timing and helpers of the display host interface.
// Assumes: A 100 MHz reference clock on both ends.
// Notes: All pin timing of the host end is derived here from figures in ns.
package dhi_pkg;

  // ----------------------------------------------------------------------
  // Interface modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {DHI_SER3, DHI_SER4, DHI_PAR_SD, DHI_PAR_SPLIT} dhi_mode_t;

  // ----------------------------------------------------------------------
  // Timing, in ns as printed, and the derived cycle counts
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_AS_NS = 10;
  localparam int T_CYCLE_NS = 300;
  localparam int T_PWLR_NS = 150;
  localparam int T_SCYCLE_NS = 100;
  localparam logic [4:0] SETUP_CYC = 5'((T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] ACT_CYC = 5'((T_PWLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] HOLD_CYC =
    5'((T_CYCLE_NS - T_PWLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] HALF_CYC = 5'((T_SCYCLE_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Field values and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] SER_OE_MASK = 8'hFB;
  localparam logic [7:0] BUS_RESET = 8'h00;
  localparam dhi_mode_t MODE_RESET = DHI_SER4;

  // Strap pair {high, low} to mode.
  function automatic dhi_mode_t dhi_decode_mode(input logic sel_hi, input logic sel_lo);
    case ({sel_hi, sel_lo})
      2'h1: dhi_decode_mode = DHI_SER3;
      2'h0: dhi_decode_mode = DHI_SER4;
      2'h3: dhi_decode_mode = DHI_PAR_SD;
      default: dhi_decode_mode = DHI_PAR_SPLIT;
    endcase
  endfunction : dhi_decode_mode

  // Mode to strap pair {high, low}.
  function automatic logic [1:0] dhi_strap(input dhi_mode_t mode);
    case (mode)
      DHI_SER3: dhi_strap = 2'h1;
      DHI_SER4: dhi_strap = 2'h0;
      DHI_PAR_SD: dhi_strap = 2'h3;
      default: dhi_strap = 2'h2;
    endcase
  endfunction : dhi_strap

  function automatic logic dhi_is_serial(input dhi_mode_t mode);
    dhi_is_serial = (mode == DHI_SER3) || (mode == DHI_SER4);
  endfunction : dhi_is_serial

endpackage : dhi_pkg

// >>> shared/dhi_link_if.sv
// Purpose: Pin bundle between the host end and the display end.
// Assumes: The bench supplies the link clock that runs the display end.
// Notes: Undriven bus bits read low, as the board ties them to ground.
`timescale 1ns/10ps
interface dhi_link_if (
  input wire logic link_clk
);
  // Straps, reset and control pins.
  logic iface_sel_lo;
  logic iface_sel_hi;
  logic panel_reset_n;
  logic cs_n;
  logic dc_sel;
  logic rw_strobe;
  logic dir_wr;
  // Data bus drives and resolved level.
  logic [7:0] host_drv;
  logic [7:0] host_oe;
  logic [7:0] dev_drv;
  logic dev_oe;
  logic [7:0] host_bus;

  // The display end wins while it drives; otherwise the host bits or ground.
  assign host_bus = dev_oe ? dev_drv : (host_oe & host_drv);

  modport device (
    input link_clk, iface_sel_lo, iface_sel_hi, panel_reset_n, cs_n, dc_sel,
    input rw_strobe, dir_wr, host_bus,
    output dev_drv, dev_oe
  );
  modport host (
    output iface_sel_lo, iface_sel_hi, panel_reset_n, cs_n, dc_sel,
    output rw_strobe, dir_wr, host_drv, host_oe,
    input host_bus
  );
endinterface : dhi_link_if

// >>> src/dhi_buf2.sv
// Purpose: Small valid/ready buffer, two entries by default.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty are exact; a push while full is refused by in_ready.
`timescale 1ns/10ps
module dhi_buf2 #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at DEPTH so the depth need not be a power of two.
  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : PW'(wp_q + 1'b1);
    end
    if (pop) begin
      rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : PW'(rp_q + 1'b1);
    end
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  // Storage carries no reset; only the pointers and the count need one.
  always_ff @(posedge clk) begin
    mem_q <= mem_d;
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : dhi_buf2

// >>> src/dhi_host.sv
// Purpose: Host end: turns user commands into pin transfers in every mode.
// Assumes: ref_clk at 100 MHz; pin timing counted in its cycles.
// Notes: One transfer at a time; reads in serial modes are dropped.
`timescale 1ns/10ps
module dhi_host
  import dhi_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Pins toward the display.
  dhi_link_if.host link,
  // Configuration.
  input wire dhi_mode_t mode_sel,
  input wire logic panel_reset_req,
  // Command request.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_dc,
  input wire logic [7:0] cmd_data,
  // Read answer.
  output logic rsp_valid,
  output logic [7:0] rsp_data
);

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_ACT, H_HOLD, H_SLO, H_SHI} dhi_hst_t;
  dhi_hst_t st_q, st_d;
  dhi_mode_t mode_q, mode_d;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, bus_q, bus_d, oe_q, oe_d, rsp_q, rsp_d, hb1_q, hb2_q;
  logic [1:0] strap_q, strap_d;
  logic rd_q, rd_d, cs_n_q, cs_n_d, dc_q, dc_d, sa_q, sa_d, sb_q, sb_d;
  logic rv_q, rv_d, prst_n_q, prst_n_d, ser, split;

  assign ser = dhi_is_serial(mode_q);
  assign split = (mode_q == DHI_PAR_SPLIT);
  assign cmd_ready = (st_q == H_IDLE);

  // The returned bus comes from the other clock, so it is synced.
  always_ff @(posedge ref_clk) begin
    hb1_q <= link.host_bus;
    hb2_q <= hb1_q;
  end

  // Idle strobe levels are inactive: high in split mode, ground otherwise.
  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    cnt_d = cnt_q + 5'h1;
    bit_d = bit_q;
    sh_d = sh_q;
    bus_d = bus_q;
    oe_d = oe_q;
    rsp_d = rsp_q;
    rd_d = rd_q;
    cs_n_d = cs_n_q;
    dc_d = dc_q;
    sa_d = sa_q;
    sb_d = sb_q;
    rv_d = 1'b0;
    prst_n_d = ~panel_reset_req; // [RQ13]
    strap_d = dhi_strap(mode_q); // [RQ1]
    case (st_q)
      H_IDLE: begin
        cnt_d = '0;
        mode_d = mode_sel;
        cs_n_d = 1'b1;
        oe_d = 8'h00;
        sa_d = split; // [RQ9]
        sb_d = split; // [RQ9]
        if (cmd_valid && !(cmd_read && ser)) begin // [RQ18]
          st_d = H_SETUP;
          cs_n_d = 1'b0;
          rd_d = cmd_read;
          sh_d = cmd_data;
          dc_d = (mode_q == DHI_SER3) ? 1'b0 : cmd_dc; // [RQ10] [RQ11]
          if (ser) begin
            bus_d = 8'h00;
            oe_d = SER_OE_MASK; // [RQ4]
          end else begin
            bus_d = cmd_data;
            oe_d = cmd_read ? 8'h00 : 8'hFF; // [RQ2]
            sb_d = split ? 1'b1 : cmd_read; // [RQ6]
          end
        end
      end
      H_SETUP: begin
        if (cnt_q == SETUP_CYC - 5'h1) begin
          cnt_d = '0;
          if (ser) begin
            st_d = H_SLO;
            bit_d = '0;
            bus_d[1] = sh_q[7]; // [RQ3] [RQ17]
          end else begin
            st_d = H_ACT;
            if (!split) begin
              sa_d = 1'b1; // [RQ5]
            end else if (rd_q) begin
              sa_d = 1'b0; // [RQ7]
            end else begin
              sb_d = 1'b0; // [RQ8]
            end
          end
        end
      end
      H_ACT: begin
        if (cnt_q == ACT_CYC - 5'h1) begin
          cnt_d = '0;
          st_d = H_HOLD;
          rv_d = rd_q;
          rsp_d = rd_q ? hb2_q : rsp_q;
          sa_d = split; // [RQ14] [RQ16]
          sb_d = split ? 1'b1 : sb_q; // [RQ15]
        end
      end
      H_HOLD: begin
        // Select and data outlast the closing strobe edge.
        if (cnt_q == SETUP_CYC) begin
          cs_n_d = 1'b1;
          oe_d = 8'h00;
          sb_d = split;
        end
        if (cnt_q == HOLD_CYC - 5'h1) begin
          st_d = H_IDLE;
        end
      end
      H_SLO: begin
        if (cnt_q == HALF_CYC - 5'h1) begin
          cnt_d = '0;
          st_d = H_SHI;
          bus_d[0] = 1'b1; // [RQ17]
        end
      end
      H_SHI: begin
        if (cnt_q == HALF_CYC - 5'h1) begin
          cnt_d = '0;
          bus_d[0] = 1'b0;
          if (bit_q == BIT_LAST) begin
            st_d = H_HOLD;
          end else begin
            st_d = H_SLO;
            bit_d = bit_q + 3'h1;
            sh_d = {sh_q[6:0], 1'b0};
            bus_d[1] = sh_q[6]; // [RQ17]
          end
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= H_IDLE;
      mode_q <= MODE_RESET;
      cnt_q <= '0;
      bit_q <= '0;
      sh_q <= BUS_RESET;
      bus_q <= BUS_RESET;
      oe_q <= 8'h00;
      rsp_q <= BUS_RESET;
      rd_q <= 1'b0;
      cs_n_q <= 1'b1;
      dc_q <= 1'b0;
      sa_q <= 1'b0;
      sb_q <= 1'b0;
      rv_q <= 1'b0;
      prst_n_q <= 1'b0;
      strap_q <= 2'h0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      bus_q <= bus_d;
      oe_q <= oe_d;
      rsp_q <= rsp_d;
      rd_q <= rd_d;
      cs_n_q <= cs_n_d;
      dc_q <= dc_d;
      sa_q <= sa_d;
      sb_q <= sb_d;
      rv_q <= rv_d;
      prst_n_q <= prst_n_d;
      strap_q <= strap_d;
    end
  end

  assign {link.iface_sel_hi, link.iface_sel_lo} = strap_q;
  assign link.panel_reset_n = prst_n_q;
  assign link.cs_n = cs_n_q;
  assign link.dc_sel = dc_q;
  assign link.rw_strobe = sa_q;
  assign link.dir_wr = sb_q;
  assign link.host_drv = bus_q;
  assign link.host_oe = oe_q;
  assign rsp_valid = rv_q;
  assign rsp_data = rsp_q;
endmodule : dhi_host

// >>> tb/dhi_link_props.sv
// Purpose: Concurrent checks on the pins between the host end and the display end.
// Assumes: Host pins move on ref_clk; the device drive is sampled on ref_clk too.
// Notes: A split-mode strobe edge is judged only while the partner strobe is high; an enable rise always.
`timescale 1ns/10ps
module dhi_link_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Link pins.
  input wire logic iface_sel_lo,
  input wire logic iface_sel_hi,
  input wire logic panel_reset_n,
  input wire logic cs_n,
  input wire logic rw_strobe,
  input wire logic dir_wr,
  input wire logic [7:0] host_oe,
  input wire logic dev_oe
);
  // ----------------------------------------------------------------------
  // Mode decode and read wait counter
  // ----------------------------------------------------------------------
  logic ser;
  logic sd;
  logic sp;
  logic [4:0] rd_cnt_d;
  logic [4:0] rd_cnt_q;
  // Straps decoded here by hand, not through the package helper.
  assign ser = !iface_sel_hi;
  assign sd = iface_sel_hi && iface_sel_lo;
  assign sp = iface_sel_hi && !iface_sel_lo;
  // Counts how long a strobe-mode read has been open.
  always_comb begin
    rd_cnt_d = (sd && !cs_n && rw_strobe && dir_wr) ? rd_cnt_q + 5'h01 : 5'h00;
  end
  always_ff @(posedge ref_clk) begin
    rd_cnt_q <= rst ? 5'h00 : rd_cnt_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_enable_needs_select: assert property (sd && $rose(rw_strobe) |-> !cs_n)
    else $error("enable rose without select");
  a_read_open_select: assert property (sp && $fell(rw_strobe) && dir_wr |-> !cs_n)
    else $error("read strobe fell without select");
  a_write_open_select: assert property (sp && $fell(dir_wr) && rw_strobe |-> !cs_n)
    else $error("write strobe fell without select");
  a_write_latch_select: assert property (sp && $rose(dir_wr) && $past(rw_strobe) |-> !cs_n)
    else $error("write strobe rose without select");
  a_read_end_select: assert property (sp && $rose(rw_strobe) && $past(dir_wr) |-> !cs_n)
    else $error("read strobe rose without select");
  a_serial_strobes_low: assert property (ser && !cs_n |-> !rw_strobe && !dir_wr)
    else $error("strobe high in serial mode");
  a_serial_bit_float: assert property (ser && !cs_n |-> host_oe == 8'hFB)
    else $error("serial bus drive mask wrong");
  a_serial_no_drive: assert property (ser && !cs_n |-> !dev_oe)
    else $error("device drove in serial mode");
  a_read_answer_time: assert property (rd_cnt_q == 5'h0E |-> dev_oe)
    else $error("read data late");
  a_read_host_quiet: assert property (rd_cnt_q != 5'h00 |-> host_oe == 8'h00)
    else $error("host drove during read");
  a_deselect_quiet: assert property (cs_n [*6] |-> !dev_oe)
    else $error("device drove while deselected");
  a_reset_quiet: assert property (!panel_reset_n [*6] |-> !dev_oe)
    else $error("device drove in panel reset");
endmodule : dhi_link_props

// >>> tb/tb_top.sv
// Purpose: Self-checking bench joining the host end and the display end.
// Assumes: ref_clk 10 ns, link clock 6 ns, reset held for 3 cycles.
// Notes: Every mode writes, only the parallel modes read; a stalled receiver must show overrun.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; chk_a = 32'(a); chk_b = 32'(b); if (chk_a !== chk_b) begin \
  mismatches++; $display("BAD %0t got %h want %h", $time, chk_a, chk_b); end end
module tb_top;
  import dhi_pkg::*;
  // ----------------------------------------------------------------------
  // Signals, clocks and instances
  // ----------------------------------------------------------------------
  logic ref_clk = 0, link_clk = 0, rst = 1, cmd_valid = 0, cmd_read = 0, cmd_dc = 0;
  logic panel_reset_req = 0, out_ready = 1, overrun_clr = 0;
  logic [7:0] cmd_data = 8'h00, st_v = 8'h00, mem_v = 8'h00, rsp_data, out_data;
  logic cmd_ready, rsp_valid, out_valid, out_dc, overrun, rd_taken, rd_taken_dc, panel_init;
  // Each operand is evaluated once, so a popped queue entry is not lost.
  logic [31:0] chk_a, chk_b;
  dhi_mode_t mode_sel = DHI_PAR_SPLIT;
  dhi_mode_t mode_tab[4] = '{DHI_PAR_SPLIT, DHI_PAR_SD, DHI_SER3, DHI_SER4};
  logic [1:0] strap_tab[4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  logic [8:0] got_q[$];
  logic [7:0] rsp_q[$];
  int mismatches = 0, checks = 0, cyc = 0, taken = 0, taken_dc = 0;
  always #5 ref_clk = ~ref_clk;
  // Odd start offset keeps the link clock out of phase with ref_clk.
  initial #1.3 forever #3 link_clk = ~link_clk;
  dhi_link_if link (.link_clk);
  dhi_host dhi_host_inst (.ref_clk, .rst, .link(link.host), .mode_sel, .panel_reset_req,
    .cmd_valid, .cmd_ready, .cmd_read, .cmd_dc, .cmd_data, .rsp_valid, .rsp_data);
  dhi_device dhi_device_inst (.ref_clk, .rst, .link(link.device), .out_valid, .out_ready,
    .out_data, .out_dc, .overrun, .overrun_clr, .rd_status(st_v), .rd_mem(mem_v),
    .rd_taken, .rd_taken_dc, .panel_init);
  dhi_link_props dhi_link_props_inst (.ref_clk, .rst, .iface_sel_lo(link.iface_sel_lo),
    .iface_sel_hi(link.iface_sel_hi), .panel_reset_n(link.panel_reset_n),
    .cs_n(link.cs_n), .rw_strobe(link.rw_strobe), .dir_wr(link.dir_wr),
    .host_oe(link.host_oe), .dev_oe(link.dev_oe));
  // Collects delivered bytes and read answers; also cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (out_valid && out_ready) got_q.push_back({out_dc, out_data});
    if (rsp_valid) rsp_q.push_back(rsp_data);
    if (rd_taken) taken++;
    if (rd_taken && rd_taken_dc) taken_dc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // One host command, then time for the byte to cross into the device buffer.
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] d);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_dc <= dc;
    cmd_data <= d;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    repeat (10) @(posedge ref_clk);
  endtask : xfer
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    for (int m = 0; m < 4; m++) begin
      mode_sel <= mode_tab[m];
      st_v <= 8'h5A ^ 8'(m);
      mem_v <= 8'hC3 ^ 8'(m);
      repeat (10) @(posedge ref_clk);
      `CHK({link.iface_sel_hi, link.iface_sel_lo}, strap_tab[m])
      xfer(1'b0, 1'b0, 8'h1D + 8'(m));
      `CHK(got_q.pop_front(), {1'b0, 8'h1D + 8'(m)})
      xfer(1'b0, 1'b1, 8'hC6 ^ 8'(m));
      // Three-wire serial has no data/command pin, so bytes arrive as commands.
      `CHK(got_q.pop_front(), {m != 2, 8'hC6 ^ 8'(m)})
      xfer(1'b1, 1'b0, 8'h00);
      xfer(1'b1, 1'b1, 8'h00);
      `CHK(got_q.size(), 0)
      `CHK(rsp_q.size(), (m < 2) ? 2 : 0)
      if (m < 2) begin
        `CHK(rsp_q.pop_front(), 8'h5A ^ 8'(m))
        `CHK(rsp_q.pop_front(), 8'hC3 ^ 8'(m))
      end
    end
    `CHK(taken, 4)
    `CHK(taken_dc, 2)
    // Stall the receiver: the third byte must be dropped and flagged.
    mode_sel <= DHI_PAR_SD;
    out_ready <= 1'b0;
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < 3; i++) xfer(1'b0, 1'b1, 8'h11 * 8'(i + 1));
    `CHK(overrun, 1'b1)
    out_ready <= 1'b1;
    overrun_clr <= 1'b1;
    repeat (5) @(posedge ref_clk);
    overrun_clr <= 1'b0;
    `CHK(got_q.size(), 2)
    `CHK(got_q.pop_front(), 9'h111)
    `CHK(got_q.pop_front(), 9'h122)
    `CHK(overrun, 1'b0)
    panel_reset_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK(link.panel_reset_n, 1'b0)
    `CHK(panel_init, 1'b1)
    panel_reset_req <= 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK(panel_init, 1'b0)
    final_report();
  end
endmodule : tb_top
